/* src/ifewc_pkg.sv */
/*
 * Constants, register map and state type of the in-application flash
 * erase/write controller. Assumes a 50 MHz system clock.
 */
package ifewc_pkg;
  localparam int CLK_MHZ = 50;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_RST_KEY   = 8'h04;
  localparam logic [7:0] OFS_TB_CTRL   = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO   = 8'h0C;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h10;
  localparam logic [7:0] OFS_D0_LO     = 8'h14;
  localparam logic [7:0] OFS_D0_HI     = 8'h18;
  localparam logic [7:0] OFS_KEY_LO [3] = '{8'h1C, 8'h24, 8'h2C};
  localparam logic [7:0] OFS_KEY_HI [3] = '{8'h20, 8'h28, 8'h30};

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int MC_UNLOCKED = 7;
  localparam int MC_MODE_LO  = 4;
  localparam int MC_TRIGGER  = 3;
  localparam int MC_START    = 2;
  localparam int MC_RD_EN    = 1;
  localparam int MC_RD_START = 0;
  localparam int TB_TIME_SEL = 1;
  localparam int TB_CLR      = 0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [7:0] KEY_LO_VAL [3] = '{8'h00, 8'h0D, 8'hC3};
  localparam logic [7:0] KEY_HI_VAL [3] = '{8'h04, 8'h09, 8'h40};
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [4:0] PAGE_LAST   = 5'h1F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TMR_W        = 18;
  localparam int ERASE_T0_US  = 3200;
  localparam int ERASE_T1_US  = 3700;
  localparam int WRITE_T0_US  = 2200;
  localparam int WRITE_T1_US  = 3000;
  localparam int ERASE_T0_CYC = ERASE_T0_US * CLK_MHZ;
  localparam int ERASE_T1_CYC = ERASE_T1_US * CLK_MHZ;
  localparam int WRITE_T0_CYC = WRITE_T0_US * CLK_MHZ;
  localparam int WRITE_T1_CYC = WRITE_T1_US * CLK_MHZ;
  localparam int UNLOCK_CYC   = 1024;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_TIME   = 2'b01,
    ST_COMMIT = 2'b11,
    ST_FINISH = 2'b10
  } ifewc_state_t;
endpackage : ifewc_pkg

/* src/ifewc_top.sv */
/*
 * In-application flash erase/write controller: Wishbone register file,
 * unlock key sequencer, timed erase/write with page commit, word read.
 * Assumes a flash array that accepts one strobe per cycle and returns
 * read data the cycle after its read strobe.
 */
// Chosen here: register access over Wishbone and the address map.
// Functional notes
// - writing 55H to the chip reset key register resets the whole chip.
// - time select picks 3.2/2.2 ms or 3.7/3.0 ms; start clears at end.
// - unimplemented upper bits read zero and ignore writes.
// - buffer clear bit clears every word, then returns to zero.
// - 12-bit word address, low byte plus high register lower nibble.
// - data low byte write only updates that register.
// - data high byte write loads 16-bit word, then increments address; here the buffer load only happens while unlocked.
// - address increment stops at in-page address 11111b.
// - successful unlock sets unlocked flag; erase/write need that flag.
// - erase tags addresses via data high writes; only tagged words erased.
// - mode 110 plus trigger bit starts the unlock procedure timer.
// - trigger bit clears at timer expiry, key right or wrong.
// - wrong key leaves flag clear; correct key sets it.
// - software clearing the unlocked flag disables erase and write at once.
// - buffer holds 32 words of the page given by address bits 11..5.
// - mode codes 000 write, 001 erase, 011 read, 110 unlock.
// - program start launches erase or write; cleared when done.
// - buffer cleared automatically after each write operation.
// - processor is stalled while read, erase or write is active.
`timescale 1ns/1ps
module ifewc_top #(
  parameter int ERASE_T0_CYC = ifewc_pkg::ERASE_T0_CYC,
  parameter int ERASE_T1_CYC = ifewc_pkg::ERASE_T1_CYC,
  parameter int WRITE_T0_CYC = ifewc_pkg::WRITE_T0_CYC,
  parameter int WRITE_T1_CYC = ifewc_pkg::WRITE_T1_CYC
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // flash array
  output logic      [11:0] flash_addr_o,
  output logic      [15:0] flash_wdata_o,
  output logic             flash_wr_o,
  output logic             flash_erase_o,
  output logic             flash_rd_o,
  input  wire logic [15:0] flash_rdata_i,
  // system
  output logic             cpu_stall_o,
  output logic             chip_reset_o
);
  import ifewc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ifewc_state_t      state_reg;
  logic              unlocked_reg;
  logic [2:0]        mode_reg;
  logic              trigger_reg;
  logic              start_reg;
  logic              rd_en_reg;
  logic              rd_start_reg;
  logic              rd_wait_reg;
  logic              rd_cap_reg;
  logic [7:0]        rkey_reg;
  logic              time_sel_reg;
  logic [11:0]       addr_reg;
  logic [7:0]        d0_lo_reg;
  logic [7:0]        d0_hi_reg;
  logic [7:0]        key_lo_reg [3];
  logic [7:0]        key_hi_reg [3];
  logic [5:0]        seen_reg;
  logic [TMR_W-1:0]  unl_tmr_reg;
  logic [TMR_W-1:0]  tmr_reg;
  logic [TMR_W-1:0]  dur;
  logic [4:0]        cidx_reg;
  logic              op_erase_reg;
  logic [7:0]        rd_byte;
  logic              wr_en;
  logic [7:0]        wd;
  logic              wr_main;
  logic              wr_tb;
  logic              wr_d0h;
  logic              unl_expire;
  logic              key_ok;
  logic              start_ok;
  logic              start_clr;
  logic              rd_issue;
  logic [5:0]        key_hit;

  ifewc_wbuf_if wbuf ();

  ifewc_wbuf u_wbuf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .bus   (wbuf.store)
  );

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // writes land on the edge where the master sees ack high
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wd      = wb_dat_i[7:0];
  assign wr_main = wr_en && wb_adr_i == OFS_MAIN_CTRL;
  assign wr_tb   = wr_en && wb_adr_i == OFS_TB_CTRL;
  assign wr_d0h  = wr_en && wb_adr_i == OFS_D0_HI;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_comb
  begin
    rd_byte = RST_BYTE;
    case (wb_adr_i)
      OFS_MAIN_CTRL: rd_byte = {unlocked_reg, mode_reg, trigger_reg,
                                start_reg, rd_en_reg, rd_start_reg};
      OFS_RST_KEY:   rd_byte = rkey_reg;
      OFS_TB_CTRL:   rd_byte = {6'h00, time_sel_reg, wbuf.clr_busy};
      OFS_ADDR_LO:   rd_byte = addr_reg[7:0];
      OFS_ADDR_HI:   rd_byte = {4'h0, addr_reg[11:8]};
      OFS_D0_LO:     rd_byte = d0_lo_reg;
      OFS_D0_HI:     rd_byte = d0_hi_reg;
      OFS_KEY_LO[0]: rd_byte = key_lo_reg[0];
      OFS_KEY_LO[1]: rd_byte = key_lo_reg[1];
      OFS_KEY_LO[2]: rd_byte = key_lo_reg[2];
      OFS_KEY_HI[0]: rd_byte = key_hi_reg[0];
      OFS_KEY_HI[1]: rd_byte = key_hi_reg[1];
      OFS_KEY_HI[2]: rd_byte = key_hi_reg[2];
      default:       rd_byte = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= {24'h00_0000, rd_byte};
  end

  // ----------------------------------------------------------------
  // chip reset key
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rkey_reg     <= RST_BYTE;
      chip_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_en && wb_adr_i == OFS_RST_KEY)
        rkey_reg <= wd;
      chip_reset_o <= wr_en && wb_adr_i == OFS_RST_KEY && wd == CHIP_RST_KEY;
    end
  end

  // ----------------------------------------------------------------
  // unlock key sequencer
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_key
      assign key_hit[k]   = wr_en && wb_adr_i == OFS_KEY_LO[k];
      assign key_hit[k+3] = wr_en && wb_adr_i == OFS_KEY_HI[k];
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          key_lo_reg[k] <= RST_BYTE;
          key_hi_reg[k] <= RST_BYTE;
        end
        else if (ce_i)
        begin
          if (key_hit[k])
            key_lo_reg[k] <= wd;
          if (key_hit[k+3])
            key_hi_reg[k] <= wd;
        end
      end
    end
  endgenerate

  assign unl_expire = trigger_reg && unl_tmr_reg == '0;
  assign key_ok = &seen_reg &&
                  key_lo_reg[0] == KEY_LO_VAL[0] && key_hi_reg[0] == KEY_HI_VAL[0] &&
                  key_lo_reg[1] == KEY_LO_VAL[1] && key_hi_reg[1] == KEY_HI_VAL[1] &&
                  key_lo_reg[2] == KEY_LO_VAL[2] && key_hi_reg[2] == KEY_HI_VAL[2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trigger_reg <= 1'b0;
      unl_tmr_reg <= '0;
      seen_reg    <= 6'h00;
    end
    else if (ce_i)
    begin
      if (unl_expire)
        trigger_reg <= 1'b0;
      else if (!trigger_reg && wr_main && wd[MC_TRIGGER] &&
               wd[MC_MODE_LO+:3] == MODE_UNLOCK)
      begin
        trigger_reg <= 1'b1;
        unl_tmr_reg <= TMR_W'(UNLOCK_CYC - 1);
        seen_reg    <= 6'h00;
      end
      else if (trigger_reg)
      begin
        unl_tmr_reg <= unl_tmr_reg - 1'b1;
        seen_reg    <= seen_reg | key_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // main control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unlocked_reg <= 1'b0;
      mode_reg     <= MODE_WRITE;
      rd_en_reg    <= 1'b0;
      time_sel_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (unl_expire && key_ok)
        unlocked_reg <= 1'b1;
      else if (wr_main && !wd[MC_UNLOCKED])
        unlocked_reg <= 1'b0;
      if (wr_main)
      begin
        mode_reg  <= wd[MC_MODE_LO+:3];
        rd_en_reg <= wd[MC_RD_EN];
      end
      if (wr_tb)
        time_sel_reg <= wd[TB_TIME_SEL];
    end
  end

  assign start_ok = unlocked_reg && (mode_reg == MODE_WRITE || mode_reg == MODE_ERASE);
  assign start_clr = (state_reg == ST_IDLE && start_reg && !start_ok) ||
                     state_reg == ST_FINISH;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_reg <= 1'b0;
    else if (ce_i)
    begin
      if (wr_main && wd[MC_START])
        start_reg <= 1'b1;
      else if (start_clr)
        start_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address and data0 registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr_reg <= 12'h000;
    else if (ce_i)
    begin
      if (wr_en && wb_adr_i == OFS_ADDR_LO)
        addr_reg[7:0] <= wd;
      else if (wr_en && wb_adr_i == OFS_ADDR_HI)
        addr_reg[11:8] <= wd[3:0];
      else if (wr_d0h && addr_reg[4:0] != PAGE_LAST)
        addr_reg <= addr_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      d0_lo_reg <= RST_BYTE;
      d0_hi_reg <= RST_BYTE;
    end
    else if (ce_i)
    begin
      if (rd_cap_reg)
      begin
        d0_lo_reg <= flash_rdata_i[7:0];
        d0_hi_reg <= flash_rdata_i[15:8];
      end
      else
      begin
        if (wr_en && wb_adr_i == OFS_D0_LO)
          d0_lo_reg <= wd;
        if (wr_d0h)
          d0_hi_reg <= wd;
      end
    end
  end

  assign wbuf.load      = wr_d0h && unlocked_reg;
  assign wbuf.load_idx  = addr_reg[4:0];
  assign wbuf.load_data = {wd, d0_lo_reg};
  assign wbuf.rd_idx    = cidx_reg;
  assign wbuf.clr_start = (wr_tb && wd[TB_CLR]) ||
                          (state_reg == ST_FINISH && !op_erase_reg);

  // ----------------------------------------------------------------
  // erase / write sequencer
  // ----------------------------------------------------------------
  // duration select
  always_comb
  begin
    if (mode_reg == MODE_ERASE)
      dur = time_sel_reg ? TMR_W'(ERASE_T1_CYC - 1) : TMR_W'(ERASE_T0_CYC - 1);
    else
      dur = time_sel_reg ? TMR_W'(WRITE_T1_CYC - 1) : TMR_W'(WRITE_T0_CYC - 1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg    <= ST_IDLE;
      tmr_reg      <= '0;
      cidx_reg     <= 5'h00;
      op_erase_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state_reg)
        ST_IDLE:
          if (start_reg && start_ok)
          begin
            state_reg    <= ST_TIME;
            tmr_reg      <= dur;
            op_erase_reg <= mode_reg == MODE_ERASE;
          end
        ST_TIME:
          // losing the unlock aborts with the array untouched
          if (!unlocked_reg)
            state_reg <= ST_FINISH;
          else if (tmr_reg == '0)
          begin
            state_reg <= ST_COMMIT;
            cidx_reg  <= 5'h00;
          end
          else
            tmr_reg <= tmr_reg - 1'b1;
        ST_COMMIT:
        begin
          cidx_reg <= cidx_reg + 5'h01;
          if (cidx_reg == PAGE_LAST)
            state_reg <= ST_FINISH;
        end
        ST_FINISH:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flash strobes and read path
  // ----------------------------------------------------------------
  assign rd_issue = rd_start_reg && !rd_wait_reg && state_reg == ST_IDLE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_start_reg <= 1'b0;
      rd_wait_reg  <= 1'b0;
      rd_cap_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_main && wd[MC_RD_START] && wd[MC_RD_EN] &&
          wd[MC_MODE_LO+:3] == MODE_READ)
        rd_start_reg <= 1'b1;
      else if (rd_cap_reg)
        rd_start_reg <= 1'b0;
      rd_wait_reg <= rd_issue || (rd_wait_reg && !rd_cap_reg);
      rd_cap_reg  <= flash_rd_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flash_addr_o  <= 12'h000;
      flash_wdata_o <= 16'h0000;
      flash_wr_o    <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_rd_o    <= 1'b0;
      cpu_stall_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      flash_addr_o  <= state_reg == ST_COMMIT ? {addr_reg[11:5], cidx_reg} : addr_reg;
      flash_wdata_o <= wbuf.rd_data;
      flash_erase_o <= state_reg == ST_COMMIT && op_erase_reg &&
                       wbuf.rd_valid && unlocked_reg;
      flash_wr_o    <= state_reg == ST_COMMIT && !op_erase_reg &&
                       wbuf.rd_valid && unlocked_reg;
      flash_rd_o    <= rd_issue;
      cpu_stall_o   <= state_reg != ST_IDLE || (start_reg && start_ok) || rd_start_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_chip_rst;
    ce_i && wr_en && wb_adr_i == OFS_RST_KEY && wd == CHIP_RST_KEY |=> chip_reset_o;
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("no chip reset on key");

  property p_addr_inc;
    ce_i && wr_d0h && addr_reg[4:0] != PAGE_LAST |=> addr_reg == $past(addr_reg) + 12'h001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not incremented");

  property p_addr_sat;
    ce_i && wr_d0h && addr_reg[4:0] == PAGE_LAST |=> addr_reg == $past(addr_reg);
  endproperty
  a_addr_sat: assert property (p_addr_sat) else $error("address left page");

  property p_locked_refuse;
    ce_i && state_reg == ST_IDLE && start_reg && !unlocked_reg && !wr_main
      |=> !start_reg && state_reg == ST_IDLE;
  endproperty
  a_locked_refuse: assert property (p_locked_refuse) else $error("locked start ran");

  property p_strobe_unlocked;
    flash_wr_o || flash_erase_o |-> $past(unlocked_reg) && $past(state_reg) == ST_COMMIT;
  endproperty
  a_strobe_unlocked: assert property (p_strobe_unlocked) else $error("strobe while locked");

  property p_trig_expire;
    ce_i && unl_expire |=> !trigger_reg;
  endproperty
  a_trig_expire: assert property (p_trig_expire) else $error("trigger stuck");

  property p_unlock_cause;
    $rose(unlocked_reg) |-> $past(unl_expire) && $past(key_ok);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without key");

  property p_read_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("upper bits not zero");

  property p_start_done;
    ce_i && state_reg == ST_FINISH && !(wr_main && wd[MC_START]) |=> !start_reg;
  endproperty
  a_start_done: assert property (p_start_done) else $error("start not cleared");
endmodule : ifewc_top

/* src/ifewc_wbuf.sv */
/*
 * 32-word page write buffer with per-word tag bits and a clear walker.
 * Assumes loads are one-cycle strobes from the controller.
 */
`timescale 1ns/1ps
module ifewc_wbuf (
  // clock, reset, enable
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  // controller side
  ifewc_wbuf_if.store bus
);
  import ifewc_pkg::*;

  logic [15:0] mem_reg [32];
  logic [31:0] valid_reg;
  logic [4:0]  ccnt_reg;
  logic        busy_reg;

  assign bus.clr_busy = busy_reg;
  assign bus.rd_data  = mem_reg[bus.rd_idx];
  assign bus.rd_valid = valid_reg[bus.rd_idx];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_reg <= 1'b0;
      ccnt_reg <= 5'h00;
    end
    else if (ce_i)
    begin
      if (!busy_reg && bus.clr_start)
      begin
        busy_reg <= 1'b1;
        ccnt_reg <= 5'h00;
      end
      else if (busy_reg)
      begin
        ccnt_reg <= ccnt_reg + 5'h01;
        if (ccnt_reg == PAGE_LAST)
          busy_reg <= 1'b0;
      end
    end
  end

  // loads during a clear are dropped so a clear always ends empty
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_word
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          valid_reg[i] <= 1'b0;
        else if (ce_i)
        begin
          if (busy_reg && ccnt_reg == 5'(i))
            valid_reg[i] <= 1'b0;
          else if (!busy_reg && bus.load && bus.load_idx == 5'(i))
            valid_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (busy_reg)
        mem_reg[ccnt_reg] <= 16'h0000;
      else if (bus.load)
        mem_reg[bus.load_idx] <= bus.load_data;
    end
  end
endmodule : ifewc_wbuf

/* src/ifewc_wbuf_if.sv */
/*
 * Link between the controller and its page write buffer.
 * Assumes both ends share the controller clock.
 */
`timescale 1ns/1ps
interface ifewc_wbuf_if;
  logic        load;
  logic [4:0]  load_idx;
  logic [15:0] load_data;
  logic        clr_start;
  logic        clr_busy;
  logic [4:0]  rd_idx;
  logic [15:0] rd_data;
  logic        rd_valid;
  modport ctrl (output load, load_idx, load_data, clr_start, rd_idx,
                input clr_busy, rd_data, rd_valid);
  modport store (input load, load_idx, load_data, clr_start, rd_idx,
                 output clr_busy, rd_data, rd_valid);
endinterface : ifewc_wbuf_if

/* tb/iap_flash_erase_write_ctrl_bench.sv */
/*
 * Self-checking bench of the flash controller over Wishbone.
 * Assumes the flash model answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
module iap_flash_erase_write_ctrl_bench;
  import ifewc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ce = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, stall, chip_rst, f_wr, f_er, f_rd;
  logic [11:0] f_a;
  logic [15:0] f_wd, f_rd_d;
  logic [7:0] r;
  int err_total = 0, checks = 0, wr_cnt = 0, rst_cnt = 0, er_cnt = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) wr_cnt <= wr_cnt + int'(f_wr);
  always @(posedge clk_i) er_cnt <= er_cnt + int'(f_er);
  always @(posedge clk_i) rst_cnt <= rst_cnt + int'(chip_rst);
  ifewc_top #(.ERASE_T0_CYC(20), .ERASE_T1_CYC(25), .WRITE_T0_CYC(10), .WRITE_T1_CYC(15)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .flash_addr_o(f_a), .flash_wdata_o(f_wd), .flash_wr_o(f_wr),
    .flash_erase_o(f_er), .flash_rd_o(f_rd), .flash_rdata_i(f_rd_d),
    .cpu_stall_o(stall), .chip_reset_o(chip_rst));
  ifewc_flash_model FLASH (.clk_i(clk_i), .flash_addr_i(f_a), .flash_wdata_i(f_wd),
    .flash_wr_i(f_wr), .flash_erase_i(f_er), .flash_rd_i(f_rd), .flash_rdata_o(f_rd_d));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o[7:0];
    cyc <= 0; stb <= 0; we <= 0;
  end
  endtask : bus
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  end
  endtask : chk
  task unlock(input logic [7:0] k0);
  begin
    bus(1, OFS_MAIN_CTRL, 8'hE8);
    bus(0, OFS_MAIN_CTRL, 0); chk(r[3], 1);
    bus(1, OFS_KEY_LO[0], k0);
    for (int i = 1; i < 3; i++) bus(1, OFS_KEY_LO[i], KEY_LO_VAL[i]);
    for (int i = 0; i < 3; i++) bus(1, OFS_KEY_HI[i], KEY_HI_VAL[i]);
    repeat (UNLOCK_CYC + 20) @(posedge clk_i);
    bus(0, OFS_MAIN_CTRL, 0); chk(r[3], 0);
  end
  endtask : unlock
  task give_verdict;
  begin
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end
  endtask : give_verdict
  initial begin #400us; err_total++; give_verdict; end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    bus(1, OFS_TB_CTRL, 8'hFE); bus(0, OFS_TB_CTRL, 0); chk(r, 8'h02);
    bus(1, OFS_ADDR_HI, 8'hFF); bus(0, OFS_ADDR_HI, 0); chk(r, 8'h0F);
    bus(1, OFS_RST_KEY, 8'h54); repeat (3) @(posedge clk_i); chk(rst_cnt, 0);
    bus(1, OFS_RST_KEY, CHIP_RST_KEY); repeat (3) @(posedge clk_i); chk(rst_cnt, 1);
    $display("regs done");
    bus(1, OFS_ADDR_HI, 0); bus(1, OFS_ADDR_LO, 8'h3E);
    bus(1, OFS_D0_LO, 8'h11); bus(0, OFS_ADDR_LO, 0); chk(r, 8'h3E);
    bus(1, OFS_D0_HI, 8'h22); bus(0, OFS_ADDR_LO, 0); chk(r, 8'h3F);
    bus(1, OFS_D0_HI, 8'h22); bus(0, OFS_ADDR_LO, 0); chk(r, 8'h3F);
    bus(1, OFS_MAIN_CTRL, 8'h04); repeat (3) @(posedge clk_i);
    bus(0, OFS_MAIN_CTRL, 0); chk(r[2], 0); chk(wr_cnt, 0);
    unlock(8'h01); bus(0, OFS_MAIN_CTRL, 0); chk(r[7], 0);
    unlock(KEY_LO_VAL[0]); bus(0, OFS_MAIN_CTRL, 0); chk(r[7], 1);
    $display("unlock done");
    bus(1, OFS_ADDR_LO, 8'h40); bus(1, OFS_D0_HI, 8'h00); bus(1, OFS_D0_HI, 8'h00);
    bus(1, OFS_MAIN_CTRL, 8'h94); bus(0, OFS_MAIN_CTRL, 0);
    for (int i = 0; i < 40 && r[2] !== 1'b0; i++) bus(0, OFS_MAIN_CTRL, 0);
    chk(r[2], 0); chk(er_cnt, 2);
    chk(FLASH.mem[12'h040], 16'h0000); chk(FLASH.mem[12'h041], 16'h0000);
    bus(1, OFS_TB_CTRL, 8'h03); bus(0, OFS_TB_CTRL, 0); chk(r[0], 1);
    for (int i = 0; i < 20 && r[0] !== 1'b0; i++) bus(0, OFS_TB_CTRL, 0);
    chk(r, 8'h02);
    $display("erase done");
    bus(1, OFS_ADDR_LO, 8'h40);
    for (int i = 0; i < 2; i++)
    begin
      bus(1, OFS_D0_LO, 8'h34 + 8'(i)); bus(1, OFS_D0_HI, 8'hA0 + 8'(i));
    end
    bus(1, OFS_MAIN_CTRL, 8'h84); ce <= 0;
    repeat (100) @(posedge clk_i);
    chk(wr_cnt, 0); ce <= 1;
    repeat (2) @(posedge clk_i);
    chk(stall, 1); bus(0, OFS_MAIN_CTRL, 0);
    for (int i = 0; i < 40 && r[2] !== 1'b0; i++) bus(0, OFS_MAIN_CTRL, 0);
    chk(r[2], 0); chk(wr_cnt, 2); chk(stall, 0);
    chk(FLASH.mem[12'h040], 16'hA034); chk(FLASH.mem[12'h041], 16'hA135);
    bus(1, OFS_ADDR_LO, 8'h40); bus(1, OFS_MAIN_CTRL, 8'hB3); bus(0, OFS_MAIN_CTRL, 0);
    for (int i = 0; i < 10 && r[0] !== 1'b0; i++) bus(0, OFS_MAIN_CTRL, 0);
    bus(0, OFS_D0_LO, 0); chk(r, 8'h34); bus(0, OFS_D0_HI, 0); chk(r, 8'hA0);
    bus(1, OFS_MAIN_CTRL, 8'h00); bus(0, OFS_MAIN_CTRL, 0); chk(r[7], 0);
    $display("ops done");
    give_verdict;
  end
endmodule : iap_flash_erase_write_ctrl_bench

/* tb/ifewc_flash_model.sv */
/*
 * Behavioural flash array on the far side of the controller.
 * Assumes one strobe per cycle; read data is valid only in the cycle after flash_rd_i.
 */
`timescale 1ns/1ps
module ifewc_flash_model (
  // clock
  input  wire logic        clk_i,
  // controller side
  input  wire logic [11:0] flash_addr_i,
  input  wire logic [15:0] flash_wdata_i,
  input  wire logic        flash_wr_i,
  input  wire logic        flash_erase_i,
  input  wire logic        flash_rd_i,
  output logic      [15:0] flash_rdata_o
);
  logic [15:0] mem [4096];
  initial flash_rdata_o = 16'h0000;
  always_ff @(posedge clk_i)
  begin
    if (flash_wr_i) mem[flash_addr_i] <= flash_wdata_i;
    if (flash_erase_i) mem[flash_addr_i] <= 16'h0000;
    // data is stale outside its cycle, so the bus toggles
    if (flash_rd_i) flash_rdata_o <= mem[flash_addr_i];
    else flash_rdata_o <= ~flash_rdata_o;
  end
endmodule : ifewc_flash_model
